/* rtl/tlv_xfer_pkg.sv */
// Constants, status words and carrier types for the segmented object handler
package tlv_xfer_pkg;
	localparam int CHANNELS = 4;
	localparam int CH_W = 2;
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [15:0] SW_MORE_OUT = 16'h62f1;
	localparam logic [15:0] SW_MORE_OUT_PRO = 16'h62f2;
	localparam logic [15:0] SW_MORE_IN = 16'h63f1;
	localparam logic [15:0] SW_MORE_IN_PRO = 16'h63f2;
	localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
	localparam logic [15:0] SW_BAD_DATA = 16'h6a80;
	localparam logic [15:0] SW_NOT_FOUND = 16'h6a88;
	localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
	localparam logic [15:0] SW_INS_UNSUP = 16'h6d00;
	localparam logic [7:0] TAG_LIST = 8'h5c;
	localparam logic [7:0] TAG_PRIM_LO = 8'h80;
	localparam logic [7:0] TAG_PRIM_HI = 8'h9e;
	localparam logic [7:0] TAG_CONS_LO = 8'ha0;
	localparam logic [7:0] TAG_CONS_HI = 8'hbe;
	localparam logic [7:0] TAG_PRIM_EXT = 8'h9f;
	localparam logic [7:0] TAG_CONS_EXT = 8'hbf;
	localparam logic [7:0] TAG2_LO = 8'h1f;
	localparam logic [7:0] TAG2_HI = 8'h7f;
	localparam logic [7:0] TAG3_MID_LO = 8'h81;
	localparam logic [7:0] TAG3_LAST_HI = 8'h7f;
	localparam logic [7:0] LEN_SHORT_HI = 8'h7f;
	localparam logic [7:0] LEN_ONE = 8'h81;
	localparam logic [7:0] LEN_TWO = 8'h82;
	localparam logic [7:0] LEN_THREE = 8'h83;
	localparam logic [7:0] LEN_ONE_MIN = 8'h80;

	typedef enum logic [1:0] {op_retrieve, op_set, op_other} op_t;
	typedef enum logic [1:0] {blk_first, blk_next, blk_retx, blk_rfu} blk_t;

	typedef struct packed {
		logic valid;
		logic [CH_W-1:0] chan;
		op_t op;
		blk_t blk;
		logic supported;
		logic touches_ef_or_tag;
		logic proactive_pending;
		logic [1:0] tag_len;
		logic [23:0] tag;
		logic [2:0] len_cnt;
		logic [31:0] len_field;
		logic obj_found;
		logic [23:0] obj_len;
		logic [15:0] blk_bytes;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic [CH_W-1:0] chan;
		logic [15:0] sw;
		logic commit;
		logic complete;
		logic abort;
		logic [23:0] offset;
		logic [15:0] bytes;
	} rsp_t;

	typedef struct packed {
		logic open;
		logic done;
		logic is_set;
		logic prev_err;
		logic [23:0] tag;
		logic [23:0] total;
		logic [23:0] offset;
		logic [15:0] last_bytes;
	} ctx_t;
endpackage

/* rtl/tlv_segmented_object_transfer.sv */
// Per-channel segmented data object transfer handler
`timescale 1ns/1ps
// Rules of the document, for this block and for the terminal
// (RQ1) Object is tag, length, then value
// (RQ2) Primitive tags only from three context ranges
// (RQ3) Constructed tags only from three context ranges
// (RQ4) Terminal keeps tags unique per file
// (RQ5) Tag list tag never allocated itself
// (RQ6) Length uses short, 81, 82, 83 forms
// (RQ7) Only minimal length encodings accepted
// (RQ8) Separate transfer context per logical channel
// (RQ9) Terminal uses current file after first
// (RQ10) Segments are placed in order
// (RQ11) Transfer starts first block, continues next
// (RQ12) More-data status on all but last
// (RQ13) File or pointer change aborts transfer
// (RQ14) Successful first block reloads pointer always
// (RQ15) Terminal handles pending proactive command
// (RQ16) Error status leaves context untouched
// (RQ17) Retransmit only after successful previous block
// (RQ18) Terminal repeats parameters on retransmit
// (RQ19) Unsupported command gets unsupported status
// (RQ20) Terminal avoids tag list mid-transfer
// (RQ21) Outgoing more status 62F1 or 62F2
// (RQ22) Incoming 63F1/63F2, then 9000 complete
// (RQ23) Next block after completion gets 6A86
// (RQ24) Bad length forms rejected, context kept
// (RQ25) Byte count tracked against object length
module tlv_segmented_object_transfer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input tlv_xfer_pkg::cmd_t cmd,
	output tlv_xfer_pkg::rsp_t rsp
);
	tlv_xfer_pkg::ctx_t ctx_r [tlv_xfer_pkg::CHANNELS];
	tlv_xfer_pkg::ctx_t ctx_nxt [tlv_xfer_pkg::CHANNELS];
	tlv_xfer_pkg::rsp_t rsp_r;
	tlv_xfer_pkg::rsp_t rsp_nxt;
	tlv_xfer_pkg::ctx_t cur;
	tlv_xfer_pkg::ctx_t upd;
	logic [24:0] len_dec;
	logic tag_ok;
	logic is_list;
	logic [23:0] blk24;
	logic [23:0] total;
	logic [23:0] rem;
	logic [23:0] start;
	logic [23:0] seg;
	logic [23:0] end_pos;
	logic fail;
	logic [15:0] fail_sw;

	function automatic logic tag_in_range(input logic [1:0] n, input logic [23:0] t);
		logic ok;
		ok = 1'b0;
		case (n)
			2'd1: begin
				ok = (t[23:16] >= tlv_xfer_pkg::TAG_PRIM_LO && t[23:16] <= tlv_xfer_pkg::TAG_PRIM_HI) ||
					(t[23:16] >= tlv_xfer_pkg::TAG_CONS_LO && t[23:16] <= tlv_xfer_pkg::TAG_CONS_HI); // RQ2 RQ3
			end
			2'd2: begin
				ok = (t[23:16] == tlv_xfer_pkg::TAG_PRIM_EXT || t[23:16] == tlv_xfer_pkg::TAG_CONS_EXT) &&
					t[15:8] >= tlv_xfer_pkg::TAG2_LO && t[15:8] <= tlv_xfer_pkg::TAG2_HI; // RQ2 RQ3
			end
			2'd3: begin
				ok = (t[23:16] == tlv_xfer_pkg::TAG_PRIM_EXT || t[23:16] == tlv_xfer_pkg::TAG_CONS_EXT) &&
					t[15:8] >= tlv_xfer_pkg::TAG3_MID_LO && t[7:0] <= tlv_xfer_pkg::TAG3_LAST_HI; // RQ2 RQ3
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// Bit 24 flags a valid minimal encoding; low bits carry the value
	function automatic logic [24:0] len_decode(input logic [2:0] n, input logic [31:0] f);
		logic [24:0] r;
		r = '0;
		case (n)
			3'd1: begin
				r = {f[31:24] <= tlv_xfer_pkg::LEN_SHORT_HI, 16'h0000, f[31:24]}; // RQ6 RQ7
			end
			3'd2: begin
				r = {f[31:24] == tlv_xfer_pkg::LEN_ONE && f[23:16] >= tlv_xfer_pkg::LEN_ONE_MIN,
					16'h0000, f[23:16]}; // RQ6 RQ7 RQ24
			end
			3'd3: begin
				r = {f[31:24] == tlv_xfer_pkg::LEN_TWO && f[23:16] != 8'h00,
					8'h00, f[23:8]}; // RQ6 RQ7 RQ24
			end
			3'd4: begin
				r = {f[31:24] == tlv_xfer_pkg::LEN_THREE && f[23:16] != 8'h00, f[23:0]}; // RQ6 RQ24
			end
			default: begin
				r = '0; // RQ24
			end
		endcase
		return r;
	endfunction

	function automatic logic [15:0] more_sw(input logic set_dir, input logic pro);
		logic [15:0] s;
		if (set_dir) begin
			s = pro ? tlv_xfer_pkg::SW_MORE_IN_PRO : tlv_xfer_pkg::SW_MORE_IN; // RQ22
		end else begin
			s = pro ? tlv_xfer_pkg::SW_MORE_OUT_PRO : tlv_xfer_pkg::SW_MORE_OUT; // RQ21
		end
		return s;
	endfunction

	always_comb begin
		for (int i = 0; i < tlv_xfer_pkg::CHANNELS; i++) begin
			ctx_nxt[i] = ctx_r[i];
		end
		rsp_nxt = '0;
		cur = ctx_r[cmd.chan]; // RQ8
		upd = cur;
		tag_ok = tag_in_range(cmd.tag_len, cmd.tag);
		is_list = cmd.tag_len == 2'd1 && cmd.tag[23:16] == tlv_xfer_pkg::TAG_LIST;
		len_dec = len_decode(cmd.len_cnt, cmd.len_field);
		blk24 = {8'h00, cmd.blk_bytes};
		total = (cmd.op == tlv_xfer_pkg::op_set) ? len_dec[23:0] : cmd.obj_len; // RQ1
		rem = cur.total - cur.offset;
		start = cur.offset - {8'h00, cur.last_bytes};
		seg = '0;
		end_pos = '0;
		fail = 1'b0;
		fail_sw = tlv_xfer_pkg::SW_OK;
		if (cmd.valid) begin
			rsp_nxt.chan = cmd.chan;
			if (cmd.op == tlv_xfer_pkg::op_other) begin
				if (cmd.touches_ef_or_tag) begin
					upd.open = 1'b0; // RQ13
					upd.done = 1'b0; // RQ13
					rsp_nxt.abort = cur.open; // RQ13
				end
			end else begin
				rsp_nxt.valid = 1'b1;
				if (!cmd.supported) begin
					fail = 1'b1;
					fail_sw = tlv_xfer_pkg::SW_INS_UNSUP; // RQ19
				end else begin
					case (cmd.blk)
						tlv_xfer_pkg::blk_first: begin
							if (!(tag_ok || (is_list && cmd.op == tlv_xfer_pkg::op_retrieve))) begin
								fail = 1'b1; // RQ5
								fail_sw = tlv_xfer_pkg::SW_BAD_DATA;
							end else if (cmd.op == tlv_xfer_pkg::op_set && !len_dec[24]) begin
								fail = 1'b1; // RQ24
								fail_sw = tlv_xfer_pkg::SW_BAD_DATA;
							end else if (cmd.op == tlv_xfer_pkg::op_retrieve && !cmd.obj_found) begin
								fail = 1'b1;
								fail_sw = tlv_xfer_pkg::SW_NOT_FOUND;
							end else if (cmd.op == tlv_xfer_pkg::op_set && blk24 > total) begin
								fail = 1'b1;
								fail_sw = tlv_xfer_pkg::SW_WRONG_LEN;
							end else begin
								seg = (blk24 < total) ? blk24 : total;
								start = '0;
								upd.open = 1'b1; // RQ14
								upd.is_set = cmd.op == tlv_xfer_pkg::op_set;
								upd.tag = cmd.tag; // RQ14
								upd.total = total; // RQ25
								end_pos = seg;
							end
						end
						tlv_xfer_pkg::blk_next: begin
							if (cur.done || !cur.open || cur.is_set != (cmd.op == tlv_xfer_pkg::op_set)) begin
								fail = 1'b1; // RQ11 RQ23
								fail_sw = tlv_xfer_pkg::SW_BAD_P1P2;
							end else if (cur.is_set && blk24 > rem) begin
								fail = 1'b1;
								fail_sw = tlv_xfer_pkg::SW_WRONG_LEN;
							end else begin
								seg = (blk24 < rem) ? blk24 : rem;
								start = cur.offset; // RQ10
								end_pos = cur.offset + seg; // RQ25
							end
						end
						tlv_xfer_pkg::blk_retx: begin
							// A repeat rewinds to where the previous block started
							if (!(cur.open || cur.done) || cur.prev_err ||
								cur.is_set != (cmd.op == tlv_xfer_pkg::op_set)) begin
								fail = 1'b1; // RQ17
								fail_sw = tlv_xfer_pkg::SW_BAD_P1P2;
							end else if (cur.is_set && start + blk24 > cur.total) begin
								fail = 1'b1;
								fail_sw = tlv_xfer_pkg::SW_WRONG_LEN;
							end else begin
								seg = cur.is_set ? blk24 : {8'h00, cur.last_bytes};
								end_pos = start + seg; // RQ17
							end
						end
						default: begin
							fail = 1'b1;
							fail_sw = tlv_xfer_pkg::SW_BAD_P1P2;
						end
					endcase
				end
				if (fail) begin
					upd = cur; // RQ16
					upd.prev_err = 1'b1; // RQ17
					rsp_nxt.sw = fail_sw;
				end else begin
					upd.offset = end_pos; // RQ25
					upd.last_bytes = seg[15:0];
					upd.prev_err = 1'b0;
					upd.done = end_pos == upd.total; // RQ25
					upd.open = end_pos != upd.total;
					rsp_nxt.commit = 1'b1;
					rsp_nxt.offset = start;
					rsp_nxt.bytes = seg[15:0];
					rsp_nxt.complete = end_pos == upd.total;
					rsp_nxt.sw = (end_pos == upd.total) ? tlv_xfer_pkg::SW_OK :
						more_sw(upd.is_set, cmd.proactive_pending); // RQ12 RQ21 RQ22
				end
			end
			ctx_nxt[cmd.chan] = upd; // RQ8
		end
	end

	for (genvar g = 0; g < tlv_xfer_pkg::CHANNELS; g++) begin : g_ctx
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				ctx_r[g] <= '0;
			end else begin
				ctx_r[g] <= ctx_nxt[g]; // RQ8
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign rsp = rsp_r;
endmodule

/* verification/terminal_model.sv */
// Terminal side model issuing one command a call
`timescale 1ns/1ps
module terminal_model (
	input wire logic core_clk,
	output tlv_xfer_pkg::cmd_t cmd
);
	initial cmd = '0;
	// Idle fields show inverted values so stale data cannot pass
	task automatic send(input tlv_xfer_pkg::cmd_t c);
		@(posedge core_clk);
		#1 cmd = c;
		@(posedge core_clk);
		#1 cmd = {1'b0, ~c[$bits(c)-2:0]};
	endtask
endmodule

/* verification/tlv_xfer_chk_props.sv */
// Port checks for the segmented object handler
`timescale 1ns/1ps
module tlv_xfer_chk (
	input wire logic core_clk,
	input wire logic sys_rst,
	input tlv_xfer_pkg::cmd_t cmd,
	input tlv_xfer_pkg::rsp_t rsp
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic dop;
	logic oth;
	assign oth = cmd.valid && cmd.op == tlv_xfer_pkg::op_other;
	assign dop = cmd.valid && !oth;
	AST_ANSWER: assert property (dop |=> rsp.valid && rsp.chan == $past(cmd.chan))
		else $error("no answer on request channel");
	AST_QUIET: assert property (!cmd.valid |=> !rsp.valid && !rsp.abort)
		else $error("answer without request");
	AST_OTHER: assert property (oth |=> !rsp.valid)
		else $error("status on interleaved command");
	AST_UNSUP: assert property (dop && !cmd.supported |=> rsp.sw == 16'h6d00 && !rsp.commit)
		else $error("unsupported not refused");
	AST_RFU: assert property (dop && cmd.supported && cmd.blk == tlv_xfer_pkg::blk_rfu
		|=> rsp.sw == 16'h6a86)
		else $error("reserved block code accepted");
	AST_LIST: assert property (dop && cmd.supported && cmd.op == tlv_xfer_pkg::op_set
		&& cmd.blk == tlv_xfer_pkg::blk_first && cmd.tag[23:16] == 8'h5c
		|=> rsp.sw == 16'h6a80)
		else $error("list tag written");
	AST_DONE: assert property (rsp.complete |-> rsp.valid && rsp.sw == 16'h9000)
		else $error("complete without final status");
	AST_MORE: assert property (rsp.commit && !rsp.complete
		|-> rsp.sw inside {16'h62f1, 16'h62f2, 16'h63f1, 16'h63f2})
		else $error("missing more data status");
	AST_PRO: assert property (rsp.valid && rsp.sw inside {16'h62f2, 16'h63f2}
		|-> $past(cmd.proactive_pending))
		else $error("pending status without cause");
	C_DONE: cover property (rsp.complete);
	C_ABORT: cover property (rsp.abort);
	C_LATE: cover property (rsp.sw == 16'h6a86);
endmodule
bind tlv_segmented_object_transfer tlv_xfer_chk chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.cmd(cmd), .rsp(rsp));

/* verification/tlv_segmented_object_transfer_test.sv */
// Self-checking bench for the segmented object handler
`timescale 1ns/1ps
module tlv_segmented_object_transfer_test;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	tlv_xfer_pkg::cmd_t cmd;
	tlv_xfer_pkg::cmd_t c;
	tlv_xfer_pkg::rsp_t rsp;
	int n_mismatch = 0;
	int checked = 0;
	logic [31:0] seed = 32'h7bc8;
	logic [35:0] lens [8] = '{{3'd1, 32'h7f000000, 1'b1}, {3'd1, 32'h80000000, 1'b0},
		{3'd2, 32'h817f0000, 1'b0}, {3'd2, 32'h81800000, 1'b1}, {3'd3, 32'h8200ff00, 1'b0},
		{3'd3, 32'h82010000, 1'b1}, {3'd4, 32'h8300ffff, 1'b0}, {3'd4, 32'h83010000, 1'b1}};
	logic [25:0] tg [6] = '{{2'd1, 24'h5c0000}, {2'd1, 24'h9e0000}, {2'd2, 24'h9f1e00},
		{2'd2, 24'hbf7f00}, {2'd3, 24'h9f8080}, {2'd3, 24'hbfff7f}};
	always #25 core_clk = ~core_clk;
	terminal_model term (.core_clk(core_clk), .cmd(cmd));
	tlv_segmented_object_transfer dut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd),
		.rsp(rsp));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic tag_ok(input logic [1:0] n, input logic [23:0] t);
		case (n)
			2'd1: return t[23:16] inside {[8'h80:8'h9e], [8'ha0:8'hbe]};
			2'd2: return t[23:16] inside {8'h9f, 8'hbf} && t[15:8] inside {[8'h1f:8'h7f]};
			2'd3: return t[23:16] inside {8'h9f, 8'hbf} && t[15] && t[14:8] != 0 && !t[7];
			default: return 1'b0;
		endcase
	endfunction
	task automatic check(input string nm, input logic [23:0] s, input logic [23:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Block codes: 0 first, 1 next, 2 retransmit, 3 reserved
	task automatic go(input logic [1:0] b, input logic [15:0] n, input logic [15:0] sw,
		input logic [23:0] off);
		logic cm;
		cm = sw == 16'h9000 || sw[15:9] == 7'h31;
		c.valid = 1'b1;
		c.blk = tlv_xfer_pkg::blk_t'(b);
		c.blk_bytes = n;
		term.send(c);
		check("status", rsp.sw, sw);
		check("channel", rsp.chan, c.chan);
		if (cm) check("offset", rsp.offset, off);
		check("commit", rsp.commit, cm);
		if (cm && c.op == tlv_xfer_pkg::op_set) check("bytes", rsp.bytes, n);
	endtask
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		c = '0;
		c.supported = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		c.op = tlv_xfer_pkg::op_set;
		c.tag = 24'h800000;
		c.tag_len = 2'd1;
		c.len_cnt = 3'd1;
		c.len_field = 32'h0a000000;
		go(2'd0, 4, 16'h63f1, 0);
		go(2'd1, 7, 16'h6700, 0);
		go(2'd2, 4, 16'h6a86, 0);
		go(2'd1, 6, 16'h9000, 4);
		check("complete", rsp.complete, 1);
		go(2'd1, 1, 16'h6a86, 0);
		$display("set transfer done");
		c.op = tlv_xfer_pkg::op_retrieve;
		c.chan = 2'd1;
		c.tag = 24'h9f1f00;
		c.tag_len = 2'd2;
		c.obj_found = 1'b1;
		c.obj_len = 24'd10;
		c.proactive_pending = 1'b1;
		go(2'd0, 4, 16'h62f2, 0);
		c.proactive_pending = 1'b0;
		c.chan = 2'd2;
		go(2'd1, 4, 16'h6a86, 0);
		c.chan = 2'd1;
		go(2'd2, 4, 16'h62f1, 0);
		go(2'd1, 4, 16'h62f1, 4);
		go(2'd3, 4, 16'h6a86, 0);
		c.op = tlv_xfer_pkg::op_other;
		term.send(c);
		check("abort", rsp.abort, 0);
		c.op = tlv_xfer_pkg::op_retrieve;
		go(2'd1, 4, 16'h9000, 8);
		check("bytes", rsp.bytes, 2);
		go(2'd0, 4, 16'h62f1, 0);
		go(2'd1, 4, 16'h62f1, 4);
		go(2'd0, 4, 16'h62f1, 0);
		c.op = tlv_xfer_pkg::op_other;
		c.touches_ef_or_tag = 1'b1;
		term.send(c);
		check("abort", rsp.abort, 1);
		c.op = tlv_xfer_pkg::op_retrieve;
		go(2'd1, 4, 16'h6a86, 0);
		$display("retrieve transfer done");
		c.supported = 1'b0;
		go(2'd0, 1, 16'h6d00, 0);
		c.supported = 1'b1;
		$display("unsupported done");
		c.op = tlv_xfer_pkg::op_set;
		c.chan = 2'd3;
		c.len_field = 32'h05000000;
		for (int i = 0; i < 46; i++) begin
			c.tag_len = 2'(rnd() % 3 + 1);
			c.tag = {2'b10, 22'(rnd())};
			if (i < 6) {c.tag_len, c.tag} = tg[i];
			go(2'd0, 1, tag_ok(c.tag_len, c.tag) ? 16'h63f1 : 16'h6a80, 0);
		end
		$display("tag ranges done");
		c.tag = 24'h810000;
		c.tag_len = 2'd1;
		for (int i = 0; i < 8; i++) begin
			{c.len_cnt, c.len_field} = lens[i][35:1];
			go(2'd0, 1, lens[i][0] ? 16'h63f1 : 16'h6a80, 0);
		end
		$display("length forms done");
		// Mid-run reset must drop the open transfer on channel 3
		sys_rst = 1'b1;
		@(posedge core_clk);
		#1 sys_rst = 1'b0;
		check("reset status", rsp.sw, 0);
		go(2'd1, 1, 16'h6a86, 0);
		$display("reset done");
		finish_test();
	end
endmodule
